// [rtl/cgm_pkg.sv]
// What this block does
// - main oscillator stop with detection on forces system clock to slow oscillator
// - stop detection can halt motor and general timer output pins
// - multiplier reference is main oscillator or fast oscillator 32 MHz divided by 4
// - multiplier input divider ratio is 1, 2 or 4
// - multiplication factor 4 to 15.5 in steps of 0.5
// - fast on-chip oscillator offers 32 MHz or 64 MHz
// - slow on-chip oscillator runs at 4 MHz
// - watchdog oscillator at 15 kHz feeds only the watchdog
// - core, fast periph, periph, converter, flash clocks divide separately
// - four-bit select fields for fast periph, periph, converter, flash clocks
// - accuracy measurement clock equals its source oscillator frequency
// - core clock feeds processor, transfer controller, program and data memory
// - one-byte stop control with enable and irq enable, separate status
// - sleep, software standby and deep sleep modes exist
// - deep sleep enable bit in third stop register picks deep sleep unless the software standby bit is set
// - power mode register selects high-speed or middle-speed operation
// - stop bits gate module clocks; bits 2 to 5 gate timer pairs
package cgm_pkg;
    localparam logic [7:0] SYS_CLK_CTRL = 8'h00;
    localparam logic [7:0] SRC_CTRL = 8'h04;
    localparam logic [7:0] OSC_STOP_CTRL = 8'h08;
    localparam logic [7:0] STOP_STATUS = 8'h0c;
    localparam logic [7:0] STANDBY_CTRL = 8'h10;
    localparam logic [7:0] MSTOP_A = 8'h14;
    localparam logic [7:0] MSTOP_B = 8'h18;
    localparam logic [7:0] MSTOP_C = 8'h1c;
    localparam logic [7:0] POWER_MODE = 8'h20;

    localparam int CONV_DIV_LSB = 0;
    localparam int PERIPH_DIV_LSB = 8;
    localparam int FAST_DIV_LSB = 12;
    localparam int CORE_DIV_LSB = 24;
    localparam int FLASH_DIV_LSB = 28;
    localparam int SRC_SEL_LSB = 0;
    localparam int PLL_REF_BIT = 4;
    localparam int PLL_DIV_LSB = 8;
    localparam int PLL_MULT_LSB = 16;
    localparam int FAST_64M_BIT = 24;
    localparam int STOP_IRQ_EN_BIT = 0;
    localparam int STOP_DET_EN_BIT = 7;
    localparam int STOP_FLAG_BIT = 0;
    localparam int SW_STANDBY_BIT = 15;
    localparam int DEEP_SLEEP_BIT = 31;
    localparam int POWER_MID_BIT = 4;
    localparam int TIMER_PAIR3_BIT = 2;
    localparam int TIMER_PAIR0_BIT = 5;

    localparam logic [1:0] SRC_MAIN = 2'h0;
    localparam logic [1:0] SRC_FAST = 2'h1;
    localparam logic [1:0] SRC_SLOW = 2'h2;
    localparam logic [1:0] SRC_PLL = 2'h3;

    localparam int OSC_MAIN = 0;
    localparam int OSC_FAST = 1;
    localparam int OSC_SLOW = 2;
    localparam int OSC_WDT = 3;
    localparam int OSC_PLL = 4;
    localparam int NUM_OSC = 5;
    localparam int NUM_DIV = 5;

    localparam logic [4:0] PLL_MULT_MAX = 5'h17;
    localparam logic [1:0] FAST_REF_LAST = 2'h3;

    localparam logic [31:0] SYS_CLK_RST = 32'h0000_0000;
    localparam logic [31:0] SRC_CTRL_RST = 32'h0000_0002;
    localparam logic [7:0] OSC_STOP_RST = 8'h00;
    localparam logic [15:0] STANDBY_RST = 16'h0000;
    localparam logic [31:0] MSTOP_A_RST = 32'hffff_ffff;
    localparam logic [31:0] MSTOP_B_RST = 32'hffff_ffff;
    localparam logic [31:0] MSTOP_C_RST = 32'h7fff_ffff;
    localparam logic [7:0] POWER_MODE_RST = 8'h00;

    localparam int CLK_PERIOD_NS = 25;
    localparam int STOP_TIMEOUT_NS = 4000;
    localparam int STOP_CYCLES_INT =
        (STOP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STOP_CYCLES = 8'(STOP_CYCLES_INT);

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cgm_bus_req_s;

    typedef struct packed {
        logic core_clock;
        logic fast_periph_clock;
        logic periph_clock;
        logic converter_clock;
        logic flash_if_clock;
        logic can_module_clock;
        logic accuracy_meas_clock;
        logic watchdog_clock;
    } cgm_clk_en_s;

    typedef enum logic [1:0] {
        LP_RUN,
        LP_SLEEP,
        LP_DEEP,
        LP_STBY
    } cgm_lp_state_e;
endpackage

// [rtl/cgm_top.sv]
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module cgm_top
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire cgm_pkg::cgm_bus_req_s bus_req,
    output logic [31:0] bus_rdata,
    input wire logic main_osc_in,
    input wire logic fast_onchip_osc_in,
    input wire logic slow_onchip_osc_in,
    input wire logic watchdog_osc_in,
    input wire logic pll_osc_in,
    input wire logic sleep_req,
    input wire logic wake_req,
    output cgm_pkg::cgm_clk_en_s clk_en,
    output logic [31:0] module_clk_en_a,
    output logic [31:0] module_clk_en_b,
    output logic [31:0] module_clk_en_c,
    output logic pll_ref_clk_en,
    output logic [4:0] pll_mult_code,
    output logic fast_osc_64m,
    output logic timer_out_stop,
    output logic stop_irq_req,
    output logic power_mode_mid,
    output logic [1:0] lp_mode
);
    import cgm_pkg::*;

    function automatic logic [5:0] div_mask(input logic [3:0] code);
        case (code)
            4'h0: div_mask = 6'h00;
            4'h1: div_mask = 6'h01;
            4'h2: div_mask = 6'h03;
            4'h3: div_mask = 6'h07;
            4'h4: div_mask = 6'h0f;
            4'h5: div_mask = 6'h1f;
            default: div_mask = 6'h3f;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic [NUM_OSC-1:0] osc_s1;
    logic [NUM_OSC-1:0] osc_s2;
    logic [NUM_OSC-1:0] osc_s3;
    logic [31:0] sys_clk_ctrl;
    logic [31:0] src_ctrl;
    logic [7:0] osc_stop_ctrl;
    logic [15:0] standby_ctrl;
    logic [31:0] mstop_a;
    logic [31:0] mstop_b;
    logic [31:0] mstop_c;
    logic [7:0] power_mode;
    logic stop_flag;
    logic [7:0] main_idle_cnt;
    logic [1:0] act_src;
    logic [3:0] act_div [NUM_DIV];
    logic [5:0] div_cnt [NUM_DIV];
    logic [1:0] fast_ref_cnt;
    logic [1:0] pll_in_cnt;
    cgm_lp_state_e lp_state;
    cgm_lp_state_e next_lp_state;
    cgm_clk_en_s next_clk_en;
    logic [31:0] rd_value;

    wire [NUM_OSC-1:0] osc_raw = {pll_osc_in, watchdog_osc_in,
        slow_onchip_osc_in, fast_onchip_osc_in, main_osc_in};
    wire [NUM_OSC-1:0] osc_tick = osc_s2 & ~osc_s3;

    wire wr_sys = bus_req.wr && hit(bus_req.addr, SYS_CLK_CTRL);
    wire wr_src = bus_req.wr && hit(bus_req.addr, SRC_CTRL);
    wire wr_ostop = bus_req.wr && hit(bus_req.addr, OSC_STOP_CTRL);
    wire wr_status = bus_req.wr && hit(bus_req.addr, STOP_STATUS);
    wire wr_stby = bus_req.wr && hit(bus_req.addr, STANDBY_CTRL);
    wire wr_ma = bus_req.wr && hit(bus_req.addr, MSTOP_A);
    wire wr_mb = bus_req.wr && hit(bus_req.addr, MSTOP_B);
    wire wr_mc = bus_req.wr && hit(bus_req.addr, MSTOP_C);
    wire wr_pwr = bus_req.wr && hit(bus_req.addr, POWER_MODE);

    wire det_en = osc_stop_ctrl[STOP_DET_EN_BIT];
    wire stop_seen = det_en && !osc_tick[OSC_MAIN] &&
        (main_idle_cnt == STOP_CYCLES - 8'h01);
    wire stop_clr = wr_status && bus_req.wdata[STOP_FLAG_BIT];
    wire next_stop_flag = stop_seen || (stop_flag && !stop_clr);

    wire [4:0] wr_mult = bus_req.wdata[PLL_MULT_LSB +: 5];
    wire [4:0] mult_sat = (wr_mult > PLL_MULT_MAX) ? PLL_MULT_MAX : wr_mult;

    // input synchronisers and edge detect
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_s1 <= '0;
            osc_s2 <= '0;
            osc_s3 <= '0;
        end
        else if (ce)
        begin
            osc_s1 <= osc_raw;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    // register file writes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sys_clk_ctrl <= SYS_CLK_RST;
            src_ctrl <= SRC_CTRL_RST;
            osc_stop_ctrl <= OSC_STOP_RST;
            standby_ctrl <= STANDBY_RST;
            mstop_a <= MSTOP_A_RST;
            mstop_b <= MSTOP_B_RST;
            mstop_c <= MSTOP_C_RST;
            power_mode <= POWER_MODE_RST;
        end
        else if (ce)
        begin
            if (wr_sys)
                sys_clk_ctrl <= bus_req.wdata;
            if (wr_src)
                src_ctrl <= {bus_req.wdata[31:21], mult_sat,
                    bus_req.wdata[15:0]};
            if (wr_ostop)
                osc_stop_ctrl <= bus_req.wdata[7:0];
            if (wr_stby)
                standby_ctrl <= bus_req.wdata[15:0];
            if (wr_ma)
                mstop_a <= bus_req.wdata;
            if (wr_mb)
                mstop_b <= bus_req.wdata;
            if (wr_mc)
                mstop_c <= bus_req.wdata;
            if (wr_pwr)
                power_mode <= bus_req.wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            main_idle_cnt <= 8'h00;
            stop_flag <= 1'b0;
        end
        else if (ce)
        begin
            if (osc_tick[OSC_MAIN])
                main_idle_cnt <= 8'h00;
            else if (main_idle_cnt != STOP_CYCLES)
                main_idle_cnt <= main_idle_cnt + 8'h01;
            stop_flag <= next_stop_flag;
        end
    end

    wire [1:0] eff_src = stop_flag ? SRC_SLOW : act_src;
    wire src_tick = (eff_src == SRC_MAIN) ? osc_tick[OSC_MAIN] :
        (eff_src == SRC_FAST) ? osc_tick[OSC_FAST] :
        (eff_src == SRC_SLOW) ? osc_tick[OSC_SLOW] : osc_tick[OSC_PLL];

    wire [3:0] req_div [NUM_DIV];
    assign req_div[0] = sys_clk_ctrl[CORE_DIV_LSB +: 4];
    assign req_div[1] = sys_clk_ctrl[FAST_DIV_LSB +: 4];
    assign req_div[2] = sys_clk_ctrl[PERIPH_DIV_LSB +: 4];
    assign req_div[3] = sys_clk_ctrl[CONV_DIV_LSB +: 4];
    assign req_div[4] = sys_clk_ctrl[FLASH_DIV_LSB +: 4];

    wire [NUM_DIV-1:0] cnt_zero;
    wire [NUM_DIV-1:0] div_tick;
    wire cfg_boundary = (&cnt_zero) && !src_tick;

    genvar g;
    generate
        for (g = 0; g < NUM_DIV; g++)
        begin : g_div
            wire wrap = (div_cnt[g] == div_mask(act_div[g]));
            assign cnt_zero[g] = (div_cnt[g] == 6'h00);
            assign div_tick[g] = src_tick && wrap;
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    div_cnt[g] <= 6'h00;
                else if (ce && src_tick)
                    div_cnt[g] <= wrap ? 6'h00 : div_cnt[g] + 6'h01;
            end
            // ratio taken only at common boundary
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    act_div[g] <= 4'h0;
                else if (ce && cfg_boundary)
                    act_div[g] <= req_div[g];
            end
        end
    endgenerate

    // source taken only at common boundary
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            act_src <= SRC_SLOW;
        else if (ce && cfg_boundary)
            act_src <= src_ctrl[SRC_SEL_LSB +: 2];
    end

    wire fast_quarter = osc_tick[OSC_FAST] && (fast_ref_cnt == FAST_REF_LAST);
    wire ref_raw = src_ctrl[PLL_REF_BIT] ? fast_quarter : osc_tick[OSC_MAIN];
    // input divider 1, 2 or 4
    wire [1:0] pll_div_code = src_ctrl[PLL_DIV_LSB +: 2];
    wire [1:0] pll_in_last = (pll_div_code == 2'h0) ? 2'h0 :
        (pll_div_code == 2'h1) ? 2'h1 : 2'h3;
    wire ref_out = ref_raw && (pll_in_cnt == pll_in_last);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fast_ref_cnt <= 2'h0;
            pll_in_cnt <= 2'h0;
        end
        else if (ce)
        begin
            if (osc_tick[OSC_FAST])
                fast_ref_cnt <= fast_ref_cnt + 2'h1;
            if (ref_raw)
                pll_in_cnt <= (pll_in_cnt == pll_in_last) ? 2'h0 :
                    pll_in_cnt + 2'h1;
        end
    end

    always_comb
    begin
        next_lp_state = lp_state;
        case (lp_state)
            LP_RUN:
                if (sleep_req)
                begin
                    if (standby_ctrl[SW_STANDBY_BIT])
                        next_lp_state = LP_STBY;
                    else if (mstop_c[DEEP_SLEEP_BIT])
                        next_lp_state = LP_DEEP;
                    else
                        next_lp_state = LP_SLEEP;
                end
            LP_SLEEP, LP_DEEP, LP_STBY:
                if (wake_req)
                    next_lp_state = LP_RUN;
            default:
                next_lp_state = LP_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lp_state <= LP_RUN;
        else if (ce)
            lp_state <= next_lp_state;
    end

    wire run = (lp_state == LP_RUN);
    wire shallow = (lp_state == LP_RUN) || (lp_state == LP_SLEEP);
    wire awake = (lp_state != LP_STBY);

    // core clock serves cpu, transfer, memories
    always_comb
    begin
        next_clk_en.core_clock = div_tick[0] && run;
        next_clk_en.fast_periph_clock = div_tick[1] && shallow;
        next_clk_en.periph_clock = div_tick[2] && awake;
        next_clk_en.converter_clock = div_tick[3] && awake;
        next_clk_en.flash_if_clock = div_tick[4] && awake;
        next_clk_en.can_module_clock = osc_tick[OSC_MAIN] && awake;
        next_clk_en.accuracy_meas_clock = osc_tick[OSC_MAIN] && awake;
        next_clk_en.watchdog_clock = osc_tick[OSC_WDT];
    end

    // read mux
    always_comb
    begin
        case (bus_req.addr)
            SYS_CLK_CTRL: rd_value = sys_clk_ctrl;
            SRC_CTRL: rd_value = src_ctrl;
            OSC_STOP_CTRL: rd_value = {24'h000000, osc_stop_ctrl};
            STOP_STATUS: rd_value = {26'h0000000, lp_state, eff_src,
                1'b0, stop_flag};
            STANDBY_CTRL: rd_value = {16'h0000, standby_ctrl};
            MSTOP_A: rd_value = mstop_a;
            MSTOP_B: rd_value = mstop_b;
            MSTOP_C: rd_value = mstop_c;
            POWER_MODE: rd_value = {24'h000000, power_mode};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // registered outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_rdata <= 32'h0000_0000;
            clk_en <= '0;
            module_clk_en_a <= 32'h0000_0000;
            module_clk_en_b <= 32'h0000_0000;
            module_clk_en_c <= 32'h0000_0000;
            pll_ref_clk_en <= 1'b0;
            pll_mult_code <= 5'h00;
            fast_osc_64m <= 1'b0;
            timer_out_stop <= 1'b0;
            stop_irq_req <= 1'b0;
            power_mode_mid <= 1'b0;
            lp_mode <= 2'h0;
        end
        else if (ce)
        begin
            bus_rdata <= bus_req.rd ? rd_value : 32'h0000_0000;
            clk_en <= next_clk_en;
            // whole pulses only, stopped modules hold state
            module_clk_en_a <= {32{next_clk_en.periph_clock}} & ~mstop_a;
            module_clk_en_b <= {32{next_clk_en.periph_clock}} & ~mstop_b;
            module_clk_en_c <= {32{next_clk_en.periph_clock}} & ~mstop_c;
            pll_ref_clk_en <= ref_out;
            // factor code, 4 plus half steps
            pll_mult_code <= src_ctrl[PLL_MULT_LSB +: 5];
            fast_osc_64m <= src_ctrl[FAST_64M_BIT];
            timer_out_stop <= next_stop_flag && det_en;
            stop_irq_req <= next_stop_flag &&
                osc_stop_ctrl[STOP_IRQ_EN_BIT];
            power_mode_mid <= power_mode[POWER_MID_BIT];
            lp_mode <= next_lp_state;
        end
    end

    chk_stop_fallback: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        $rose(stop_flag) |-> eff_src == SRC_SLOW && $past(det_en))
        else $error("no fallback to slow oscillator");
    chk_timer_halt: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        stop_flag && !stop_clr && det_en |=> timer_out_stop)
        else $error("timer outputs not halted");
    chk_pll_div_gap: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        pll_ref_clk_en && pll_div_code != 2'h0 && $stable(src_ctrl)
        |-> !$past(pll_ref_clk_en))
        else $error("reference divider pulses too close");
    chk_mult_range: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        pll_mult_code <= PLL_MULT_MAX)
        else $error("multiplier code out of range");
    chk_watchdog_clk: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        osc_tick[OSC_WDT] |=> clk_en.watchdog_clock)
        else $error("watchdog clock pulse lost");
    chk_stop_sticky: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        stop_flag && !stop_clr |=> stop_flag)
        else $error("stop flag lost without clear");
    chk_core_gated: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        lp_state != LP_RUN |=> !clk_en.core_clock)
        else $error("core clock runs in low-power mode");

    chk_deep_entry: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        run && sleep_req && mstop_c[DEEP_SLEEP_BIT] &&
        !standby_ctrl[SW_STANDBY_BIT] |=> lp_state == LP_DEEP ##1 1'b1)
        else $error("deep sleep not entered");

    chk_timer_gate: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        mstop_a[TIMER_PAIR0_BIT] && mstop_a[TIMER_PAIR3_BIT]
        |=> !module_clk_en_a[TIMER_PAIR0_BIT] &&
        !module_clk_en_a[TIMER_PAIR3_BIT])
        else $error("stopped timer pair still clocked");

    chk_src_stable: assert property (
        @(posedge clk) disable iff (!rst_n || !ce)
        !cfg_boundary |=> $stable(act_src))
        else $error("source changed off boundary");
endmodule // cgm_top

// [verification/cgm_osc_model.sv]
`timescale 1ns/1ps
module cgm_osc_model
(
    input wire logic main_run,
    output logic main_osc,
    output logic fast_osc,
    output logic slow_osc,
    output logic wdt_osc,
    output logic pll_osc
);
    initial
    begin
        {main_osc, fast_osc, slow_osc, wdt_osc, pll_osc} = 5'h00;
    end
    // haltable main, well under 20 MHz
    always #101 main_osc = main_run ? ~main_osc : 1'b0;
    always #77 fast_osc = ~fast_osc;
    always #131 slow_osc = ~slow_osc;
    always #997 wdt_osc = ~wdt_osc;
    always #89 pll_osc = ~pll_osc;
endmodule // cgm_osc_model

// [verification/cgm_top_tb.sv]
`timescale 1ns/1ps
module cgm_top_tb;
    import cgm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cgm_bus_req_s bus_req = '0;
    logic [31:0] bus_rdata;
    logic main_run = 1'b1;
    logic ce = 1'b1;
    logic sleep_req = 1'b0;
    logic wake_req = 1'b0;
    logic m_osc, f_osc, s_osc, w_osc, p_osc;
    cgm_clk_en_s clk_en;
    logic [31:0] mod_a, mod_b, mod_c, rd;
    logic pll_ref, osc64, t_stop, irq, pmid;
    logic [4:0] mult;
    logic [1:0] lp_mode;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int w, n_core, n_per, n_wdt, n_ma5, n_maz, n_mb, n_ref;
    logic [7:0] ra [10] = '{SYS_CLK_CTRL, SRC_CTRL, OSC_STOP_CTRL,
        STOP_STATUS, STANDBY_CTRL, MSTOP_A, MSTOP_B, MSTOP_C, POWER_MODE,
        8'h24};
    logic [31:0] rv [10] = '{SYS_CLK_RST, SRC_CTRL_RST, 32'(OSC_STOP_RST),
        32'h0000_0008, 32'(STANDBY_RST), MSTOP_A_RST, MSTOP_B_RST,
        MSTOP_C_RST, 32'(POWER_MODE_RST), 32'h0};
    logic [31:0] sb [3] = '{32'h0, 32'h0, 32'h8000};
    logic [31:0] mc [3] = '{32'h7fff_ffff, 32'hffff_ffff, 32'h7fff_ffff};
    logic [7:0] wa [5] = '{SYS_CLK_CTRL, SRC_CTRL, OSC_STOP_CTRL,
        POWER_MODE, 8'h24};
    logic [31:0] wd [5] = '{32'h3100_3201, 32'h011f_0113, 32'hffff_0081,
        32'h10, 32'hffff_ffff};
    logic [31:0] we [5] = '{32'h3100_3201, 32'h0117_0113, 32'h81, 32'h10,
        32'h0};

    always #12.5 clk = ~clk;

    cgm_osc_model cgm_osc_model_i (.main_run(main_run), .main_osc(m_osc),
        .fast_osc(f_osc), .slow_osc(s_osc), .wdt_osc(w_osc),
        .pll_osc(p_osc));

    cgm_top cgm_top_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .main_osc_in(m_osc),
        .fast_onchip_osc_in(f_osc), .slow_onchip_osc_in(s_osc),
        .watchdog_osc_in(w_osc), .pll_osc_in(p_osc),
        .sleep_req(sleep_req), .wake_req(wake_req), .clk_en(clk_en),
        .module_clk_en_a(mod_a), .module_clk_en_b(mod_b),
        .module_clk_en_c(mod_c), .pll_ref_clk_en(pll_ref),
        .pll_mult_code(mult), .fast_osc_64m(osc64),
        .timer_out_stop(t_stop), .stop_irq_req(irq),
        .power_mode_mid(pmid), .lp_mode(lp_mode));

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_req <= '0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        bus_req <= '0;
        #1;
        d = bus_rdata;
    endtask

    // counts enable pulses over n cycles
    task automatic count(input int n);
        {n_core, n_per, n_wdt, n_ma5, n_maz, n_mb, n_ref} = '0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            n_core += int'(clk_en.core_clock);
            n_per += int'(clk_en.periph_clock);
            n_wdt += int'(clk_en.watchdog_clock);
            n_ma5 += int'(mod_a[5]);
            n_maz += int'(|(mod_a & 32'hffff_ffdf));
            n_mb += int'(|mod_b);
            n_ref += int'(pll_ref);
        end
    endtask

    task automatic pulse_req(input logic wake);
        @(posedge clk);
        if (wake) wake_req <= 1'b1; else sleep_req <= 1'b1;
        @(posedge clk);
        {wake_req, sleep_req} <= 2'b00;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task final_report;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            final_report;
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (ra[i])
        begin
            reg_read(ra[i], rd);
            check_word(rd, rv[i]);
        end
        count(200);
        check_bit(n_ma5 == 0 && n_mb == 0 && n_per > 0, 1'b1);
        reg_write(MSTOP_A, 32'hffff_ffdf);
        count(200);
        check_bit(n_ma5 > 0 && n_maz == 0, 1'b1);
        reg_write(SYS_CLK_CTRL, 32'h0100_0000);
        count(400);
        w = n_per - 2 * n_core;
        check_bit(n_core > 0 && w <= 2 && w >= -2, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            reg_write(STANDBY_CTRL, sb[i]);
            reg_write(MSTOP_C, mc[i]);
            pulse_req(1'b0);
            check_word(32'(lp_mode), 32'(i + 1));
            count(200);
            check_bit(n_core == 0 && n_wdt > 0, 1'b1);
            check_bit(n_per > 0, i != 2);
            pulse_req(1'b1);
            check_word(32'(lp_mode), 32'h0);
        end
        reg_write(SRC_CTRL, 32'h000a_0000);
        reg_write(OSC_STOP_CTRL, 32'h81);
        count(20);
        @(posedge clk);
        main_run <= 1'b0;
        w = 0;
        while (irq !== 1'b1 && w < 400)
        begin
            @(posedge clk);
            #1;
            w++;
        end
        check_bit(w >= 150 && w < 400, 1'b1);
        check_bit(t_stop, 1'b1);
        reg_read(STOP_STATUS, rd);
        check_word(rd, 32'h0000_0009);
        @(posedge clk);
        main_run <= 1'b1;
        count(20);
        reg_write(STOP_STATUS, 32'h1);
        reg_read(STOP_STATUS, rd);
        check_word(rd & 32'h1, 32'h0);
        check_bit(irq, 1'b0);
        foreach (wa[i])
        begin
            reg_write(wa[i], wd[i]);
            reg_read(wa[i], rd);
            check_word(rd, we[i]);
        end
        check_word(32'(mult), 32'h17);
        check_bit(osc64 & pmid, 1'b1);
        count(300);
        check_bit(n_ref > 0, 1'b1);
        @(posedge clk);
        ce <= 1'b0;
        reg_write(POWER_MODE, 32'h0);
        count(40);
        check_bit(pmid && n_wdt % 40 == 0 && n_ref % 40 == 0, 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        reg_read(POWER_MODE, rd);
        check_word(rd, 32'h10);
        reg_write(SRC_CTRL, 32'h000a_0001);
        count(100);
        count(400);
        check_bit(n_core >= 31 && n_core <= 34, 1'b1);
        final_report;
    end
endmodule // cgm_top_tb
